// File: irq_pkg.sv
// Shared constants for the external interrupt and vector map block.
package irq_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int IDX_W = 8;
  localparam int PC_W = 12;
  localparam int PC_LO_W = 8;
  localparam int PC_HI_W = 4;
  localparam int VEC_W = 12;
  localparam int SLOTS = 16;
  localparam int SLOT_W = 4;
  localparam int PERIPH_W = 12;

  // ---------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_MASK_LO = 8'h0F;
  localparam logic [IDX_W-1:0] IDX_MASK_HI = 8'h10;
  localparam logic [IDX_W-1:0] IDX_PC_FLAG = 8'h11;
  localparam logic [IDX_W-1:0] IDX_PC_EN = 8'h12;
  localparam logic [IDX_W-1:0] IDX_EXT_EN = 8'h13;
  localparam logic [IDX_W-1:0] IDX_EXT_FLAG = 8'h14;
  localparam logic [IDX_W-1:0] IDX_SENSE = 8'h15;
  // Every register comes out of reset as zero.
  localparam logic [7:0] REG_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Sense selection codes for the dedicated pin
  // ---------------------------------------------------------------
  typedef logic [1:0] sense_t;
  localparam sense_t SENSE_LOW = 2'h0;
  localparam sense_t SENSE_ANY = 2'h1;
  localparam sense_t SENSE_FALL = 2'h2;
  localparam sense_t SENSE_RISE = 2'h3;

  // ---------------------------------------------------------------
  // Request slots (slot number equals position in the vector map)
  // ---------------------------------------------------------------
  localparam logic [SLOT_W-1:0] SLOT_EXT = 4'h1;
  localparam logic [SLOT_W-1:0] SLOT_PC_LO = 4'h2;
  localparam logic [SLOT_W-1:0] SLOT_PC_HI = 4'h3;
  localparam logic [SLOT_W-1:0] SLOT_PERIPH = 4'h4;

  // ---------------------------------------------------------------
  // Program addresses of the reset and interrupt vectors
  // ---------------------------------------------------------------
  localparam logic [VEC_W-1:0] reset_vector = 12'h000;
  localparam logic [VEC_W-1:0] ext_irq_vector = 12'h001;
  localparam logic [VEC_W-1:0] pin_change_lo_vector = 12'h002;
  localparam logic [VEC_W-1:0] pin_change_hi_vector = 12'h003;
  localparam logic [VEC_W-1:0] timer_capture_vector = 12'h004;
  localparam logic [VEC_W-1:0] timer_overflow_vector = 12'h005;
  localparam logic [VEC_W-1:0] timer_match_a_vector = 12'h006;
  localparam logic [VEC_W-1:0] timer_match_b_vector = 12'h007;
  localparam logic [VEC_W-1:0] comparator_vector = 12'h008;
  localparam logic [VEC_W-1:0] watchdog_timeout_vector = 12'h009;
  localparam logic [VEC_W-1:0] supply_level_monitor_vector = 12'h00A;
  localparam logic [VEC_W-1:0] converter_done_vector = 12'h00B;
  localparam logic [VEC_W-1:0] serial_rx_start_vector = 12'h00C;
  localparam logic [VEC_W-1:0] serial_rx_done_vector = 12'h00D;
  localparam logic [VEC_W-1:0] serial_tx_empty_vector = 12'h00E;
  localparam logic [VEC_W-1:0] serial_tx_done_vector = 12'h00F;

  // Slot-ordered lookup, slot 0 being the reset entry.
  localparam logic [VEC_W-1:0] VECTOR_TABLE [SLOTS] = '{
    reset_vector, ext_irq_vector, pin_change_lo_vector, pin_change_hi_vector,
    timer_capture_vector, timer_overflow_vector, timer_match_a_vector, timer_match_b_vector,
    comparator_vector, watchdog_timeout_vector, supply_level_monitor_vector, converter_done_vector,
    serial_rx_start_vector, serial_rx_done_vector, serial_tx_empty_vector, serial_tx_done_vector};

  // ---------------------------------------------------------------
  // Bus responses
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : irq_pkg

// File: ext_pin_sync.sv
// Two-flop synchroniser and edge detector for the dedicated interrupt pin.
`timescale 1ns/1ps
module ext_pin_sync
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Gated I/O clock enable.
  input wire logic sample_en,
  // Raw pin.
  input wire logic pin,
  // Detected edges, one-cycle pulses.
  output logic rise,
  output logic fall
);

  // -------------------------------------------------------------
  // State
  // -------------------------------------------------------------
  typedef struct packed
  {
    logic stage1; // First synchroniser flop, read only by stage2.
    logic stage2; // Second synchroniser flop.
    logic prev;   // Previous clean sample.
  } sync_t;

  sync_t cur;
  sync_t next_cur;

  // The synchroniser and the comparison only advance while the I/O clock runs.
  always_comb
  begin
    next_cur = cur;
    if (sample_en)
    begin
      next_cur.stage1 = pin;
      next_cur.stage2 = cur.stage1;
      next_cur.prev = cur.stage2;
    end
  end

  // Edges are only seen while the I/O clock runs.
  assign rise = sample_en & cur.stage2 & ~cur.prev;
  assign fall = sample_en & ~cur.stage2 & cur.prev;

  // Registers; reset to the idle-high level so release causes no edge.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cur <= '{stage1: 1'b1, stage2: 1'b1, prev: 1'b1};
    end
    else
    begin
      cur <= next_cur;
    end
  end

endmodule : ext_pin_sync

// File: vector_arbiter.sv
// Fixed-priority arbiter: the lowest pending slot wins.
`timescale 1ns/1ps
module vector_arbiter
(
  // Pending and enabled requests, one per slot.
  input wire logic [irq_pkg::SLOTS-1:0] req,
  // Result.
  output logic found,
  output logic [irq_pkg::SLOT_W-1:0] slot
);

  // Scanning downward lets the lowest slot overwrite higher ones.
  always_comb
  begin
    found = 1'b0;
    slot = '0;
    for (int i = irq_pkg::SLOTS - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        found = 1'b1;
        slot = irq_pkg::SLOT_W'(i);
      end
    end
  end

endmodule : vector_arbiter

// File: ext_irq_and_vector_table.sv
// External interrupt detection, pin-change masking and vector selection with an AXI4-Lite register port.
`timescale 1ns/1ps
module ext_irq_and_vector_table
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // AXI4-Lite write address channel.
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data channel.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response channel.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address channel.
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data channel.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins.
  input wire logic ext_irq_pin,
  input wire logic [irq_pkg::PC_W-1:0] pin_change_inputs,
  // Other peripherals, already gated by their own enables.
  input wire logic [irq_pkg::PERIPH_W-1:0] periph_irq,
  // Processor core.
  input wire logic global_irq_enable,
  input wire logic irq_ack,
  input wire logic sleep_active,
  input wire logic sleep_idle,
  output logic irq_req,
  output logic [irq_pkg::VEC_W-1:0] irq_vector,
  output logic reset_fetch,
  output logic wake_req
);

  // -------------------------------------------------------------
  // Decoding helpers
  // -------------------------------------------------------------

  // Word index of a byte address.
  function automatic logic [irq_pkg::IDX_W-1:0] reg_index(input logic [31:0] addr);
    reg_index = addr[irq_pkg::IDX_W+1:2];
  endfunction : reg_index

  // True when the address hits one of the seven registers.
  function automatic logic reg_mapped(input logic [31:0] addr);
    logic [irq_pkg::IDX_W-1:0] idx;
    idx = addr[irq_pkg::IDX_W+1:2];
    reg_mapped = (addr[31:irq_pkg::IDX_W+2] == '0) && (addr[1:0] == 2'h0)
                 && (idx >= irq_pkg::IDX_MASK_LO) && (idx <= irq_pkg::IDX_SENSE);
  endfunction : reg_mapped

  // -------------------------------------------------------------
  // State
  // -------------------------------------------------------------
  typedef struct packed
  {
    irq_pkg::sense_t sense;                 // Sense selection bits.
    logic ext_en;                           // Dedicated pin enable.
    logic ext_flag;                         // Dedicated pin edge flag.
    logic [1:0] pc_en;                      // Group enables.
    logic [1:0] pc_flag;                    // Group flags.
    logic [irq_pkg::PC_LO_W-1:0] mask_lo;   // Group 0 pin mask.
    logic [irq_pkg::PC_HI_W-1:0] mask_hi;   // Group 1 pin mask.
    logic [irq_pkg::PC_W-1:0] pc_prev;      // Last seen pin-change levels.
    logic aw_got;                           // Write address held.
    logic aw_ok;                            // Held write address is mapped.
    logic [irq_pkg::IDX_W-1:0] aw_idx;      // Held write index.
    logic w_got;                            // Write data held.
    logic [7:0] wbyte;                      // Held low data byte.
    logic wstrb0;                           // Held low byte strobe.
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq_req;
    logic [irq_pkg::VEC_W-1:0] irq_vector;
    logic reset_fetch;
    logic wake_req;
  } state_t;

  state_t cur;
  state_t next_cur;

  // I/O clock enable: halted in every sleep mode except idle.
  logic io_clk_en;
  assign io_clk_en = ~sleep_active | sleep_idle;

  // Edge pulses from the synchroniser.
  logic pin_rise;
  logic pin_fall;

  ext_pin_sync u_pin_sync
  (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .sample_en(io_clk_en),
    .pin(ext_irq_pin),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // Requests handed to the arbiter, built from next-state values.
  logic [irq_pkg::SLOTS-1:0] slot_req;
  logic arb_found;
  logic [irq_pkg::SLOT_W-1:0] arb_slot;

  vector_arbiter u_arbiter
  (
    .req(slot_req),
    .found(arb_found),
    .slot(arb_slot)
  );

  // Sources that the core's global enable does not yet gate.
  logic [irq_pkg::SLOTS-1:0] src_req;

  // -------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------

  // One process for detection, flags, the bus slave and the core port.
  always_comb
  begin
    logic level_mode;
    logic edge_hit;
    logic [irq_pkg::PC_W-1:0] toggled;
    logic do_write;
    logic ack_ext;
    logic ack_lo;
    logic ack_hi;
    level_mode = 1'b0;
    edge_hit = 1'b0;
    toggled = '0;
    do_write = 1'b0;
    ack_ext = 1'b0;
    ack_lo = 1'b0;
    ack_hi = 1'b0;
    next_cur = cur;
    next_cur.reset_fetch = 1'b0;

    // Acknowledge clears the flag of the vector being served.
    if (irq_ack && cur.irq_req)
    begin
      ack_ext = (cur.irq_vector == irq_pkg::VECTOR_TABLE[irq_pkg::SLOT_EXT]);
      ack_lo = (cur.irq_vector == irq_pkg::VECTOR_TABLE[irq_pkg::SLOT_PC_LO]);
      ack_hi = (cur.irq_vector == irq_pkg::VECTOR_TABLE[irq_pkg::SLOT_PC_HI]);
    end

    // Write channels: each is taken on its own, in either order.
    if (s_axi_awvalid && cur.awready)
    begin
      next_cur.aw_got = 1'b1;
      next_cur.aw_ok = reg_mapped(s_axi_awaddr);
      next_cur.aw_idx = reg_index(s_axi_awaddr);
    end
    if (s_axi_wvalid && cur.wready)
    begin
      next_cur.w_got = 1'b1;
      next_cur.wbyte = s_axi_wdata[7:0];
      next_cur.wstrb0 = s_axi_wstrb[0];
    end

    // Both halves held and no response pending: perform the write.
    if (cur.aw_got && cur.w_got && !cur.bvalid)
    begin
      do_write = cur.aw_ok && cur.wstrb0;
      next_cur.aw_got = 1'b0;
      next_cur.w_got = 1'b0;
      next_cur.bvalid = 1'b1;
      next_cur.bresp = cur.aw_ok ? irq_pkg::RESP_OKAY : irq_pkg::RESP_SLVERR;
    end
    else if (cur.bvalid && s_axi_bready)
    begin
      next_cur.bvalid = 1'b0;
    end

    // Register writes; flags clear on a written one, a set below wins.
    if (do_write)
    begin
      case (cur.aw_idx)
        irq_pkg::IDX_MASK_LO: next_cur.mask_lo = cur.wbyte;
        irq_pkg::IDX_MASK_HI: next_cur.mask_hi = cur.wbyte[irq_pkg::PC_HI_W-1:0];
        irq_pkg::IDX_PC_FLAG: next_cur.pc_flag = cur.pc_flag & ~cur.wbyte[1:0];
        irq_pkg::IDX_PC_EN: next_cur.pc_en = cur.wbyte[1:0];
        irq_pkg::IDX_EXT_EN: next_cur.ext_en = cur.wbyte[0];
        irq_pkg::IDX_EXT_FLAG: next_cur.ext_flag = cur.ext_flag & ~cur.wbyte[0];
        irq_pkg::IDX_SENSE: next_cur.sense = cur.wbyte[1:0];
        default: next_cur.sense = next_cur.sense;
      endcase
    end
    if (ack_ext)
    begin
      next_cur.ext_flag = 1'b0;
    end
    if (ack_lo)
    begin
      next_cur.pc_flag[0] = 1'b0;
    end
    if (ack_hi)
    begin
      next_cur.pc_flag[1] = 1'b0;
    end

    // Dedicated pin: select the active condition from the sense code.
    case (cur.sense)
      irq_pkg::SENSE_LOW: level_mode = 1'b1;
      irq_pkg::SENSE_ANY: edge_hit = pin_rise | pin_fall;
      irq_pkg::SENSE_FALL: edge_hit = pin_fall;
      irq_pkg::SENSE_RISE: edge_hit = pin_rise;
      default: level_mode = 1'b0;
    endcase
    // The pin is read whatever its direction, so software can trigger it.
    if (edge_hit)
    begin
      next_cur.ext_flag = 1'b1;
    end
    if (level_mode)
    begin
      next_cur.ext_flag = 1'b0;
    end

    // Pin-change inputs are compared every cycle, I/O clock or not.
    toggled = pin_change_inputs ^ cur.pc_prev;
    next_cur.pc_prev = pin_change_inputs;
    if (|(toggled[irq_pkg::PC_LO_W-1:0] & cur.mask_lo))
    begin
      next_cur.pc_flag[0] = 1'b1;
    end
    if (|(toggled[irq_pkg::PC_W-1:irq_pkg::PC_LO_W] & cur.mask_hi))
    begin
      next_cur.pc_flag[1] = 1'b1;
    end

    // Per-source requests; a level request lives only while the pin is low.
    src_req = '0;
    src_req[irq_pkg::SLOT_EXT] = next_cur.ext_en
                                 & (level_mode ? ~ext_irq_pin : next_cur.ext_flag);
    src_req[irq_pkg::SLOT_PC_LO] = next_cur.pc_en[0] & next_cur.pc_flag[0];
    src_req[irq_pkg::SLOT_PC_HI] = next_cur.pc_en[1] & next_cur.pc_flag[1];
    src_req[irq_pkg::SLOTS-1:irq_pkg::SLOT_PERIPH] = periph_irq;
    slot_req = global_irq_enable ? src_req : '0;

    // Wake needs no I/O clock; a vanished low level drops it again.
    next_cur.wake_req = sleep_active & (|src_req);

    // Core request: lowest pending slot, vector from the map.
    next_cur.irq_req = arb_found;
    if (arb_found)
    begin
      next_cur.irq_vector = irq_pkg::VECTOR_TABLE[arb_slot];
    end

    // Read channel: accept one read, answer next cycle.
    if (s_axi_arvalid && cur.arready)
    begin
      next_cur.rvalid = 1'b1;
      next_cur.rresp = reg_mapped(s_axi_araddr) ? irq_pkg::RESP_OKAY : irq_pkg::RESP_SLVERR;
      next_cur.rdata = '0;
      if (reg_mapped(s_axi_araddr))
      begin
        case (reg_index(s_axi_araddr))
          irq_pkg::IDX_MASK_LO: next_cur.rdata[irq_pkg::PC_LO_W-1:0] = cur.mask_lo;
          irq_pkg::IDX_MASK_HI: next_cur.rdata[irq_pkg::PC_HI_W-1:0] = cur.mask_hi;
          irq_pkg::IDX_PC_FLAG: next_cur.rdata[1:0] = cur.pc_flag;
          irq_pkg::IDX_PC_EN: next_cur.rdata[1:0] = cur.pc_en;
          irq_pkg::IDX_EXT_EN: next_cur.rdata[0] = cur.ext_en;
          irq_pkg::IDX_EXT_FLAG: next_cur.rdata[0] = cur.ext_flag;
          irq_pkg::IDX_SENSE: next_cur.rdata[1:0] = cur.sense;
          default: next_cur.rdata = '0;
        endcase
      end
    end
    else if (cur.rvalid && s_axi_rready)
    begin
      next_cur.rvalid = 1'b0;
    end

    // Ready flags are registered so every bus output is a flop.
    next_cur.awready = ~next_cur.aw_got & ~next_cur.bvalid;
    next_cur.wready = ~next_cur.w_got & ~next_cur.bvalid;
    next_cur.arready = ~next_cur.rvalid;
  end

  // -------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------

  // Reset presents the reset vector with a fetch strobe to the core.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cur <= '0;
      cur.sense <= irq_pkg::REG_RESET[1:0];
      cur.irq_vector <= irq_pkg::reset_vector;
      cur.reset_fetch <= 1'b1;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // -------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------
  assign s_axi_awready = cur.awready;
  assign s_axi_wready = cur.wready;
  assign s_axi_bvalid = cur.bvalid;
  assign s_axi_bresp = cur.bresp;
  assign s_axi_arready = cur.arready;
  assign s_axi_rvalid = cur.rvalid;
  assign s_axi_rdata = cur.rdata;
  assign s_axi_rresp = cur.rresp;
  assign irq_req = cur.irq_req;
  assign irq_vector = cur.irq_vector;
  assign reset_fetch = cur.reset_fetch;
  assign wake_req = cur.wake_req;

endmodule : ext_irq_and_vector_table

// File: ext_irq_checker_assertions.sv
// Concurrent checks on the ports of the interrupt and vector block.
`timescale 1ns/1ps
module ext_irq_checker
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register bus signals.
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // Core side.
  input wire logic global_irq_enable,
  input wire logic sleep_active,
  input wire logic irq_req,
  input wire logic [irq_pkg::VEC_W-1:0] irq_vector,
  input wire logic reset_fetch,
  input wire logic wake_req
);
  // ----------------------------------------------------------------
  // Properties, all on the system clock.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_rst_vec; $fell(sys_rst) |-> reset_fetch && irq_vector == 12'h000; endproperty
  a_rst_vec: assert property (p_rst_vec) else $error("no start at zero after reset");
  property p_vec_range; irq_req |-> irq_vector inside {[12'h001:12'h00F]}; endproperty
  a_vec_range: assert property (p_vec_range) else $error("vector outside the map");
  property p_global; irq_req |-> $past(global_irq_enable); endproperty
  a_global: assert property (p_global) else $error("request without global enable");
  property p_wake; wake_req |-> $past(sleep_active); endproperty
  a_wake: assert property (p_wake) else $error("wake while awake");
  property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
endmodule : ext_irq_checker

// File: core_model.sv
// Processor core stand-in that enters vectored handlers.
`timescale 1ns/1ps
module core_model
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Request side.
  input wire logic irq_req,
  input wire logic [irq_pkg::VEC_W-1:0] irq_vector,
  input wire logic slow,
  output logic irq_ack,
  // Record of entered handlers.
  output logic [irq_pkg::VEC_W-1:0] taken_vec,
  output int taken
);
  // Cycles waited before entering a handler.
  int wait_cnt = 0;
  initial
  begin
    irq_ack = 1'b0;
    taken_vec = 12'h000;
    taken = 0;
  end
  // A slow core waits, so requests must hold until taken.
  always @(posedge clk_sys)
  begin
    irq_ack <= 1'b0;
    if (sys_rst)
      wait_cnt <= 0;
    else if (irq_req && !irq_ack && wait_cnt >= (slow ? 3 : 0))
    begin
      irq_ack <= 1'b1;
      taken_vec <= irq_vector;
      taken <= taken + 1;
      wait_cnt <= 0;
    end
    else if (irq_req && !irq_ack)
      wait_cnt <= wait_cnt + 1;
  end
endmodule : core_model

// File: ext_irq_and_vector_table_tb_top.sv
// Self-checking bench for the interrupt detection and vector block.
`timescale 1ns/1ps
module ext_irq_and_vector_table_tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic ext_irq_pin = 1'b1, global_irq_enable = 1'b0, sleep_active = 1'b0, sleep_idle = 1'b0, slow = 1'b0;
  logic [11:0] pin_change_inputs = 12'h000, periph_irq = 12'h000;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_req, reset_fetch, wake_req, irq_ack;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [irq_pkg::VEC_W-1:0] irq_vector, taken_vec;
  int taken, errors = 0, cmp_count = 0;
  localparam logic [1:0] ok = irq_pkg::RESP_OKAY;
  initial forever #2 clk_sys = ~clk_sys;
  ext_irq_and_vector_table dut_u (.*);
  core_model core_u (.*);
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    $display("TB: errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  // AW and W go out together; each drops when taken.
  task automatic axi_write(input logic [7:0] idx, input logic [7:0] v, input logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= {22'h000000, idx, 2'h0};
    s_axi_wdata <= {24'h000000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready)
      begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge clk_sys);
    s_axi_bready <= 1'b1;
    @(posedge clk_sys);
    check(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_araddr <= {22'h000000, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge clk_sys);
    s_axi_rready <= 1'b1;
    @(posedge clk_sys);
    check(s_axi_rdata, exp);
    check(s_axi_rresp, er);
    s_axi_rready <= 1'b0;
  endtask : axi_read
  task automatic do_reset;
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (16) @(posedge clk_sys);
    check({reset_fetch, irq_vector}, 13'h1000);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check(reset_fetch, 1'b0);
  endtask : do_reset
  // Drives pins, counts handlers entered; hits below zero means at least one.
  task automatic step(input logic e, input logic [11:0] p, input int hits, input logic [11:0] v);
    int n0;
    n0 = taken;
    @(posedge clk_sys);
    ext_irq_pin <= e;
    pin_change_inputs <= p;
    repeat (14) @(posedge clk_sys);
    if (hits < 0)
      check(taken > n0, 1'b1);
    else
      check(taken - n0, hits);
    if (hits != 0)
      check(taken_vec, v);
  endtask : step
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    for (logic [7:0] i = irq_pkg::IDX_MASK_LO; i <= irq_pkg::IDX_SENSE; i++)
      axi_read(i, 32'h0, ok);
    axi_write(irq_pkg::IDX_SENSE, 8'h03, ok);
    axi_read(irq_pkg::IDX_SENSE, 32'h3, ok);
    axi_write(8'h00, 8'h01, irq_pkg::RESP_SLVERR);
    axi_read(8'h00, 32'h0, irq_pkg::RESP_SLVERR);
    do_reset();
    axi_read(irq_pkg::IDX_SENSE, 32'h0, ok);
  endtask : t_regs
  task automatic t_pin_change;
    global_irq_enable <= 1'b1;
    step(1'b1, 12'h001, 0, 12'h000);
    axi_write(irq_pkg::IDX_MASK_LO, 8'h01, ok);
    axi_write(irq_pkg::IDX_MASK_HI, 8'h01, ok);
    axi_write(irq_pkg::IDX_PC_EN, 8'h03, ok);
    step(1'b1, 12'h003, 0, 12'h000);
    step(1'b1, 12'h002, 1, 12'h002);
    step(1'b1, 12'h102, 1, 12'h003);
    step(1'b1, 12'h003, 2, 12'h003);
  endtask : t_pin_change
  task automatic t_flags;
    global_irq_enable <= 1'b0;
    sleep_active <= 1'b1;
    step(1'b1, 12'h002, 0, 12'h000);
    check(wake_req, 1'b1);
    axi_read(irq_pkg::IDX_PC_FLAG, 32'h1, ok);
    axi_write(irq_pkg::IDX_PC_FLAG, 8'h01, ok);
    axi_read(irq_pkg::IDX_PC_FLAG, 32'h0, ok);
    sleep_active <= 1'b0;
    global_irq_enable <= 1'b1;
  endtask : t_flags
  task automatic t_ext;
    int n0;
    axi_write(irq_pkg::IDX_SENSE, {6'h00, irq_pkg::SENSE_FALL}, ok);
    axi_write(irq_pkg::IDX_EXT_EN, 8'h01, ok);
    step(1'b0, 12'h002, 1, 12'h001);
    step(1'b1, 12'h002, 0, 12'h000);
    axi_write(irq_pkg::IDX_SENSE, {6'h00, irq_pkg::SENSE_RISE}, ok);
    step(1'b0, 12'h002, 0, 12'h000);
    step(1'b1, 12'h002, 1, 12'h001);
    axi_write(irq_pkg::IDX_SENSE, {6'h00, irq_pkg::SENSE_ANY}, ok);
    step(1'b0, 12'h002, 1, 12'h001);
    step(1'b1, 12'h002, 1, 12'h001);
    axi_write(irq_pkg::IDX_SENSE, {6'h00, irq_pkg::SENSE_LOW}, ok);
    n0 = taken;
    ext_irq_pin <= 1'b0;
    repeat (20) @(posedge clk_sys);
    check(taken - n0 > 1, 1'b1);
    // Low level held into sleep, then let go.
    sleep_active <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check(wake_req, 1'b1);
    ext_irq_pin <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check({wake_req, irq_req}, 2'b00);
    sleep_active <= 1'b0;
    axi_read(irq_pkg::IDX_EXT_FLAG, 32'h0, ok);
    axi_write(irq_pkg::IDX_SENSE, {6'h00, irq_pkg::SENSE_FALL}, ok);
    sleep_active <= 1'b1;
    step(1'b0, 12'h002, 0, 12'h000);
    step(1'b1, 12'h002, 0, 12'h000);
    sleep_idle <= 1'b1;
    step(1'b0, 12'h002, 1, 12'h001);
    sleep_active <= 1'b0;
    sleep_idle <= 1'b0;
    step(1'b1, 12'h002, 0, 12'h000);
  endtask : t_ext
  task automatic t_periph;
    slow <= 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      periph_irq <= 12'h001 << i;
      step(1'b1, 12'h002, -1, 12'(4 + i));
      periph_irq <= 12'h000;
      repeat (8) @(posedge clk_sys);
    end
  endtask : t_periph
  initial
  begin
    do_reset();
    t_regs();
    t_pin_change();
    t_flags();
    t_ext();
    t_periph();
    close_out();
  end
  // Hang guard, well above the scenario length.
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    close_out();
  end
endmodule : ext_irq_and_vector_table_tb_top
bind ext_irq_and_vector_table ext_irq_checker chk_u (.*);
